// >>> verif/host_uart_model.sv
// host UART partner: modem lines and its transmit line
`timescale 1ns/100ps
`default_nettype none
module host_uart_model (
  input  wire logic ready_i,
  input  wire logic carrier_i,
  output var  logic rts_n_o,
  output var  logic cd_n_o,
  output var  logic tx_o
);
  assign rts_n_o = !ready_i; // low only while ready to take data
  assign cd_n_o  = !carrier_i;
  assign tx_o    = 1'b1; // holds the idle level, sends nothing
endmodule : host_uart_model
`default_nettype wire

// >>> verif/ir_bridge_assertions.sv
// concurrent checks on start-up, line timing and bus handshakes
`timescale 1ns/100ps
`default_nettype none
module ir_bridge_assertions
  import ir_bridge_pkg::*;
#(
  parameter int unsigned POWER_UP_CNT  = 8,
  parameter int unsigned OSC_START_CNT = 4
) (
  input wire logic       clk_i,
  input wire logic       arst_n_i,
  input wire logic       device_reset_n_i,
  input wire logic       host_serial_out_o,
  input wire logic       infrared_pulse_out_o,
  input wire logic       awvalid_i,
  input wire logic       awready_o,
  input wire logic       wvalid_i,
  input wire logic       wready_o,
  input wire logic [1:0] bresp_o,
  input wire logic       bvalid_o,
  input wire logic       bready_i,
  input wire logic       arvalid_i,
  input wire logic       arready_o,
  input wire logic       rvalid_o,
  input wire logic       rready_i
);
  localparam int unsigned BOOT = POWER_UP_CNT + OSC_START_CNT;
  int unsigned boot_cnt;
  int unsigned ir_hi;
  int unsigned ir_lo;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      boot_cnt <= 0;
    end else if (boot_cnt < BOOT) begin
      boot_cnt <= boot_cnt + 1;
    end
  end
  // run lengths of the infrared line
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ir_hi <= 0;
      ir_lo <= 0;
    end else begin
      ir_hi <= infrared_pulse_out_o ? ir_hi + 1 : 0;
      ir_lo <= infrared_pulse_out_o ? 0 : ir_lo + 1;
    end
  end
  AST_RST_IDLE: assert property (
    $rose(arst_n_i) |-> host_serial_out_o && !infrared_pulse_out_o)
    else $error("lines not idle after reset");
  AST_DEVRST_IDLE: assert property (
    !device_reset_n_i [*8] |-> host_serial_out_o && !infrared_pulse_out_o)
    else $error("lines not idle in device reset");
  AST_BOOT_QUIET: assert property (
    boot_cnt < BOOT |-> host_serial_out_o && !infrared_pulse_out_o)
    else $error("traffic before start-up delays");
  AST_IR_PULSE: assert property (
    $fell(infrared_pulse_out_o) && device_reset_n_i
      |-> ir_hi == 3 * TICK_DIV)
    else $error("infrared pulse width wrong");
  AST_IR_GAP: assert property (
    $rose(infrared_pulse_out_o) |-> ir_lo >= 13 * TICK_DIV)
    else $error("infrared pulses too close");
  AST_B_ANSWER: assert property (
    awvalid_i && awready_o && wvalid_i && wready_o |-> ##[1:2] bvalid_o)
    else $error("write response late");
  AST_B_DONE: assert property (
    bvalid_o && bready_i |=> !bvalid_o && awready_o && wready_o)
    else $error("write response not closed");
  AST_R_ANSWER: assert property (
    arvalid_i && arready_o |-> ##1 rvalid_o)
    else $error("read data late");
  AST_R_DONE: assert property (
    rvalid_o && rready_i |=> !rvalid_o)
    else $error("read data not closed");
  cover property ($fell(infrared_pulse_out_o));
  cover property ($rose(host_serial_out_o));
  cover property (bvalid_o && bready_i && bresp_o == RESP_SLVERR);
endmodule : ir_bridge_assertions
bind ir_bridge_host_lines_startup ir_bridge_assertions #(
  .POWER_UP_CNT(POWER_UP_CNT), .OSC_START_CNT(OSC_START_CNT)
) chk_u (.*);
`default_nettype wire

// >>> verif/tb_top.sv
// self-checking bench: start-up, host lines, serial and infrared timing
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import ir_bridge_pkg::*;
;
  localparam int unsigned PU    = 8;
  localparam int unsigned OSC   = 4;
  localparam int unsigned HOLD  = 3000;
  localparam int unsigned BIT_T = TICKS_PER_BIT * TICK_DIV;
  typedef struct packed {
    logic        rdy;
    logic        car;
    logic [7:0]  addr;
    logic [1:0]  resp;
    logic [31:0] mask;
    logic [31:0] exp;
  } row_t;
  logic        clk_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic        device_reset_n_i = 1'b1;
  logic        rdy = 1'b0;
  logic        car = 1'b0;
  logic        host_serial_in_i;
  logic        host_serial_out_o;
  logic        request_to_send_n_i;
  logic        carrier_detect_n_i;
  logic        clear_to_send_n_o;
  logic        infrared_pulse_out_o;
  logic [7:0]  awaddr_i = 8'h00;
  logic        awvalid_i = 1'b0;
  logic        awready_o;
  logic [31:0] wdata_i = 32'h0;
  logic [3:0]  wstrb_i = 4'hF;
  logic        wvalid_i = 1'b0;
  logic        wready_o;
  logic [1:0]  bresp_o;
  logic        bvalid_o;
  logic        bready_i = 1'b0;
  logic [7:0]  araddr_i = 8'h00;
  logic        arvalid_i = 1'b0;
  logic        arready_o;
  logic [31:0] rdata_o;
  logic [1:0]  rresp_o;
  logic        rvalid_o;
  logic        rready_i = 1'b0;
  int          errors = 0;
  int          num_checks = 0;
  row_t        rows [7] = '{
    '{1'h1, 1'h1, REG_STATUS, RESP_OKAY, 32'hF, 32'h7},
    '{1'h0, 1'h1, REG_STATUS, RESP_OKAY, 32'hF, 32'h3},
    '{1'h1, 1'h0, REG_STATUS, RESP_OKAY, 32'hF, 32'h5},
    '{1'h0, 1'h0, REG_STATUS, RESP_OKAY, 32'hF, 32'h1},
    '{1'h1, 1'h1, 8'h14, RESP_SLVERR, 32'hFFFFFFFF, 32'h0},
    '{1'h1, 1'h1, REG_HOST_RX, RESP_OKAY, 32'hFFFFFFFF, 32'h0},
    '{1'h1, 1'h1, REG_CTRL, RESP_OKAY, 32'h3, 32'h0}
  };
  always #2 clk_i = ~clk_i;
  ir_bridge_host_lines_startup #(
    .POWER_UP_CNT(PU), .OSC_START_CNT(OSC)
  ) dut_u (.*);
  host_uart_model model_u (
    .ready_i(rdy), .carrier_i(car), .rts_n_o(request_to_send_n_i),
    .cd_n_o(carrier_detect_n_i), .tx_o(host_serial_in_i)
  );
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test
  task automatic hang;
    errors++;
    $display("BAD %0t wait ran out", $time);
    finish_test();
  endtask : hang
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    int n = 0;
    bit aw = 1'b0;
    bit w = 1'b0;
    awaddr_i  <= a;
    wdata_i   <= d;
    awvalid_i <= 1'b1;
    wvalid_i  <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk_i);
      n++;
      if (n > 50) hang();
      if (!aw && awready_o === 1'b1) begin
        aw = 1'b1;
        awvalid_i <= 1'b0;
      end
      if (!w && wready_o === 1'b1) begin
        w = 1'b1;
        wvalid_i <= 1'b0;
      end
    end
    bready_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
      if (n > 100) hang();
    end while (bvalid_o !== 1'b1);
    r = bresp_o;
    bready_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n = 0;
    araddr_i  <= a;
    arvalid_i <= 1'b1;
    rready_i  <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
      if (n > 50) hang();
      if (arvalid_i && arready_o === 1'b1) arvalid_i <= 1'b0;
    end while (rvalid_o !== 1'b1);
    d = rdata_o;
    r = rresp_o;
  endtask : rd
  task automatic wait_for(input bit ir, input logic v, input int lim,
                          input bit must, output int n);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while ((ir ? infrared_pulse_out_o : host_serial_out_o) !== v
               && n < lim);
    if (must && n >= lim) hang();
  endtask : wait_for
  task automatic wait_run;
    logic [31:0] d;
    logic [1:0]  r;
    int          n = 0;
    do begin
      rd(REG_STATUS, d, r);
      n++;
      if (n > 40) hang();
    end while (d[ST_RUN_BIT] !== 1'b1);
  endtask : wait_run
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    repeat (20) @(posedge clk_i);
    chk(32'(host_serial_out_o), 32'h1);
    chk(32'(infrared_pulse_out_o), 32'h0);
    chk(32'(clear_to_send_n_o), 32'h1);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
    rd(REG_STATUS, d, r);
    chk(32'(d[ST_RUN_BIT]), 32'h0);
    wr(REG_HOST_TX, 32'h5A, r);
    chk(32'(r), 32'(RESP_SLVERR));
    wait_run();
    chk(32'(clear_to_send_n_o), 32'h0);
    $display("test start-up done");
    foreach (rows[i]) begin
      rdy <= rows[i].rdy;
      car <= rows[i].car;
      repeat (8) @(posedge clk_i);
      rd(rows[i].addr, d, r);
      chk(32'(r), 32'(rows[i].resp));
      chk(d & rows[i].mask, rows[i].exp);
    end
    $display("test table done");
    rdy <= 1'b0;
    repeat (8) @(posedge clk_i);
    wr(REG_HOST_TX, 32'h55, r);
    chk(32'(r), 32'(RESP_OKAY));
    wr(REG_HOST_TX, 32'h55, r);
    chk(32'(r), 32'(RESP_SLVERR));
    wait_for(1'b0, 1'b0, HOLD, 1'b0, n);
    chk(32'(n), 32'(HOLD));
    rdy <= 1'b1;
    wait_for(1'b0, 1'b0, BIT_T, 1'b1, n);
    wait_for(1'b0, 1'b1, BIT_T + 8, 1'b1, n);
    wait_for(1'b0, 1'b0, BIT_T + 8, 1'b1, n);
    chk(32'(n), 32'(BIT_T));
    $display("test host serial done");
    wr(REG_CTRL, 32'h1, r);
    wr(REG_IR_TX, 32'h0, r);
    chk(32'(r), 32'(RESP_OKAY));
    wait_for(1'b1, 1'b1, 2 * BIT_T, 1'b1, n);
    wait_for(1'b1, 1'b0, BIT_T, 1'b1, n);
    chk(32'(n), 32'(3 * TICK_DIV));
    wait_for(1'b1, 1'b1, BIT_T, 1'b1, n);
    chk(32'(n), 32'(13 * TICK_DIV));
    wstrb_i <= 4'h0;
    wr(REG_CTRL, 32'h0, r);
    wstrb_i <= 4'hF;
    chk(32'(r), 32'(RESP_OKAY));
    rd(REG_CTRL, d, r);
    chk(32'(d[CTRL_IR_EN]), 32'h1);
    $display("test infrared done");
    device_reset_n_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    chk(32'(host_serial_out_o), 32'h1);
    chk(32'(infrared_pulse_out_o), 32'h0);
    rd(REG_STATUS, d, r);
    chk(32'(d[ST_RUN_BIT]), 32'h0);
    device_reset_n_i <= 1'b1;
    wr(REG_IR_TX, 32'h0, r);
    chk(32'(r), 32'(RESP_SLVERR));
    wait_run();
    $display("test device reset done");
    finish_test();
  end
endmodule : tb_top
`default_nettype wire

// >>> verilog/byte_stream_if.sv
// byte hand-off between the register side and a serial shifter
`timescale 1ns/100ps
`default_nettype none
interface byte_stream_if;
  logic [7:0] data;
  logic       valid;
  logic       ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : byte_stream_if
`default_nettype wire

// >>> verilog/ir_bridge_host_lines_startup.sv
// host lines, start-up sequencing and fixed-rate serial timing of the bridge
//
// Design decisions made here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module ir_bridge_host_lines_startup
  import ir_bridge_pkg::*;
#(
  parameter int unsigned POWER_UP_CNT  = POWER_UP_CYCLES,
  parameter int unsigned OSC_START_CNT = OSC_START_CYCLES,
  parameter int unsigned RX_DEPTH      = HOST_RX_DEPTH,
  parameter int unsigned SLACK         = CTS_SLACK
) (
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        device_reset_n_i,
  input  wire logic        host_serial_in_i,
  output var  logic        host_serial_out_o,
  input  wire logic        request_to_send_n_i,
  input  wire logic        carrier_detect_n_i,
  output var  logic        clear_to_send_n_o,
  output var  logic        infrared_pulse_out_o,
  input  wire logic [7:0]  awaddr_i,
  input  wire logic        awvalid_i,
  output var  logic        awready_o,
  input  wire logic [31:0] wdata_i,
  input  wire logic [3:0]  wstrb_i,
  input  wire logic        wvalid_i,
  output var  logic        wready_o,
  output var  logic [1:0]  bresp_o,
  output var  logic        bvalid_o,
  input  wire logic        bready_i,
  input  wire logic [7:0]  araddr_i,
  input  wire logic        arvalid_i,
  output var  logic        arready_o,
  output var  logic [31:0] rdata_o,
  output var  logic [1:0]  rresp_o,
  output var  logic        rvalid_o,
  input  wire logic        rready_i
);
  localparam int unsigned MAX_DLY = (POWER_UP_CNT > OSC_START_CNT)
                                    ? POWER_UP_CNT : OSC_START_CNT;
  localparam int unsigned DLY_W = $clog2(MAX_DLY + 1);
  localparam int unsigned PTR_W = $clog2(RX_DEPTH);
  localparam int unsigned LVL_W = $clog2(RX_DEPTH + 1);
  localparam int unsigned DIV_W = $clog2(TICK_DIV);
  localparam logic [LVL_W-1:0] DEPTH_L = LVL_W'(RX_DEPTH);
  localparam logic [LVL_W-1:0] HOLD_L  = LVL_W'(RX_DEPTH - SLACK);

  if (RX_DEPTH < 2 || SLACK >= RX_DEPTH || POWER_UP_CNT < 1
      || OSC_START_CNT < 1 || TICK_DIV < 2) begin : g_bad_param
    $error("unsupported parameter values");
  end

  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
    ptr_inc = (p == PTR_W'(RX_DEPTH - 1)) ? '0 : p + PTR_W'(1);
  endfunction : ptr_inc

  // pin synchronisers: bit 3 reset, 2 rts, 1 carrier, 0 serial in
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [3:0] sync3_reg;
  logic [3:0] pin_reg;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync1_reg <= 4'hF;
      sync2_reg <= 4'hF;
      sync3_reg <= 4'hF;
      pin_reg   <= 4'hF;
    end else begin
      sync1_reg <= {device_reset_n_i, request_to_send_n_i,
                    carrier_detect_n_i, host_serial_in_i}; // [R14]
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      pin_reg   <= (sync2_reg & sync3_reg)
                   | (pin_reg & (sync2_reg | sync3_reg)); // [R14]
    end
  end

  logic dev_rst_n;
  logic rts_n;
  logic carrier_n;
  logic serial_in;
  assign dev_rst_n = pin_reg[3];
  assign rts_n     = pin_reg[2];
  assign carrier_n = pin_reg[1];
  assign serial_in = pin_reg[0];

  // start-up sequence: power-up delay, then oscillator start-up delay
  startup_state_t   state_reg;
  logic [DLY_W-1:0] dly_reg;
  logic             run;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= ST_POWER_UP;
      dly_reg   <= '0;
    end else if (!dev_rst_n) begin // [R7]
      state_reg <= ST_POWER_UP;
      dly_reg   <= '0;
    end else begin
      case (state_reg)
        ST_POWER_UP: begin // [R5] [R8]
          if (dly_reg == DLY_W'(POWER_UP_CNT - 1)) begin
            state_reg <= ST_OSC_START;
            dly_reg   <= '0;
          end else begin
            dly_reg <= dly_reg + DLY_W'(1);
          end
        end
        ST_OSC_START: begin // [R5] [R8]
          if (dly_reg == DLY_W'(OSC_START_CNT - 1)) begin
            state_reg <= ST_RUN;
          end else begin
            dly_reg <= dly_reg + DLY_W'(1);
          end
        end
        default: state_reg <= ST_RUN;
      endcase
    end
  end

  assign run = (state_reg == ST_RUN); // [R6]

  // bit-clock ticks, sixteen per bit, from the one system clock
  logic [DIV_W-1:0] div_reg;
  logic             tick_reg;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_reg  <= '0;
      tick_reg <= 1'b0;
    end else if (div_reg == DIV_W'(TICK_DIV - 1)) begin // [R4] [R9] [R10]
      div_reg  <= '0;
      tick_reg <= 1'b1;
    end else begin
      div_reg  <= div_reg + DIV_W'(1);
      tick_reg <= 1'b0;
    end
  end

  // host serial receiver, sampled at mid-bit
  logic       rx_active_reg;
  logic [3:0] rx_tick_reg;
  logic [3:0] rx_bit_reg;
  logic [7:0] rx_shift_reg;
  logic       rx_stop;
  logic       rx_push;

  assign rx_stop = rx_active_reg && tick_reg && rx_tick_reg == RX_MID_TICK
                   && rx_bit_reg == STOP_BIT_IDX && serial_in;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_active_reg <= 1'b0;
      rx_tick_reg   <= 4'h0;
      rx_bit_reg    <= 4'h0;
      rx_shift_reg  <= 8'h00;
    end else if (!run) begin // [R6]
      rx_active_reg <= 1'b0;
    end else if (!rx_active_reg) begin
      if (!serial_in) begin
        rx_active_reg <= 1'b1;
        rx_tick_reg   <= 4'h0;
        rx_bit_reg    <= 4'h0;
      end
    end else if (tick_reg) begin
      rx_tick_reg <= rx_tick_reg + 4'h1; // [R10]
      if (rx_tick_reg == RX_MID_TICK) begin
        rx_bit_reg <= rx_bit_reg + 4'h1;
        if (rx_bit_reg == 4'h0 && serial_in) begin
          rx_active_reg <= 1'b0;
        end else if (rx_bit_reg == STOP_BIT_IDX) begin
          rx_active_reg <= 1'b0;
        end else if (rx_bit_reg != 4'h0) begin
          rx_shift_reg <= {serial_in, rx_shift_reg[7:1]};
        end
      end
    end
  end

  // host receive buffer with clear-to-send flow control
  logic [7:0]       rx_mem [RX_DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [LVL_W-1:0] level_reg;
  logic             rx_pop;
  logic             overflow_reg;
  logic             ovf_clr;

  assign rx_push = rx_stop && level_reg != DEPTH_L; // [R13]

  always_ff @(posedge clk_i) begin
    if (rx_push) begin
      rx_mem[wr_ptr_reg] <= rx_shift_reg;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      level_reg  <= '0;
    end else if (!run) begin // [R7]
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      level_reg  <= '0;
    end else begin
      if (rx_push) begin
        wr_ptr_reg <= ptr_inc(wr_ptr_reg);
      end
      if (rx_pop) begin
        rd_ptr_reg <= ptr_inc(rd_ptr_reg);
      end
      if (rx_push && !rx_pop) begin
        level_reg <= level_reg + LVL_W'(1);
      end else if (rx_pop && !rx_push) begin
        level_reg <= level_reg - LVL_W'(1);
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      overflow_reg <= 1'b0;
    end else if (rx_stop && level_reg == DEPTH_L) begin
      overflow_reg <= 1'b1;
    end else if (ovf_clr) begin
      overflow_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      clear_to_send_n_o <= 1'b1;
    end else begin
      clear_to_send_n_o <= !run || level_reg >= HOLD_L; // [R12] [R13]
    end
  end

  // transmit paths: one to the host, one pulse-coded onto the infrared line
  byte_stream_if host_tx ();
  byte_stream_if ir_tx ();
  logic       host_pend_reg;
  logic       ir_pend_reg;
  logic [7:0] host_byte_reg;
  logic [7:0] ir_byte_reg;
  logic       ir_en_reg;

  assign host_tx.data  = host_byte_reg;
  assign host_tx.valid = host_pend_reg && !rts_n; // [R1] [R2]
  assign ir_tx.data    = ir_byte_reg;
  assign ir_tx.valid   = ir_pend_reg && ir_en_reg;

  serial_shifter #(.INFRARED(1'b0)) u_host_tx (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .run_i    (run),
    .tick_i   (tick_reg),
    .feed     (host_tx),
    .line_o   (host_serial_out_o)
  );

  serial_shifter #(.INFRARED(1'b1)) u_ir_tx (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .run_i    (run),
    .tick_i   (tick_reg),
    .feed     (ir_tx),
    .line_o   (infrared_pulse_out_o)
  );

  // register write channel; address and data accepted in either order
  logic        aw_full_reg;
  logic        w_full_reg;
  logic [7:0]  waddr_reg;
  logic [31:0] wdata_reg;
  logic        wbyte_reg;
  logic        wr_fire;
  logic        wr_err;

  assign wr_fire = aw_full_reg && w_full_reg && !bvalid_o;

  always_comb begin
    if (waddr_reg == REG_CTRL || waddr_reg == REG_STATUS
        || waddr_reg == REG_HOST_RX) begin
      wr_err = 1'b0;
    end else if (waddr_reg == REG_IR_TX) begin
      wr_err = !run || ir_pend_reg;
    end else if (waddr_reg == REG_HOST_TX) begin
      wr_err = !run || host_pend_reg;
    end else begin
      wr_err = 1'b1;
    end
  end

  assign ovf_clr = wr_fire && waddr_reg == REG_CTRL && wbyte_reg
                   && wdata_reg[CTRL_OVF_CLR];

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      awready_o   <= 1'b1;
      wready_o    <= 1'b1;
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      waddr_reg   <= 8'h00;
      wdata_reg   <= 32'h0000_0000;
      wbyte_reg   <= 1'b0;
      bvalid_o    <= 1'b0;
      bresp_o     <= RESP_OKAY;
    end else begin
      if (awvalid_i && awready_o) begin
        waddr_reg   <= awaddr_i;
        aw_full_reg <= 1'b1;
        awready_o   <= 1'b0;
      end
      if (wvalid_i && wready_o) begin
        wdata_reg  <= wdata_i;
        wbyte_reg  <= wstrb_i[0];
        w_full_reg <= 1'b1;
        wready_o   <= 1'b0;
      end
      if (wr_fire) begin
        aw_full_reg <= 1'b0;
        w_full_reg  <= 1'b0;
        bvalid_o    <= 1'b1;
        bresp_o     <= wr_err ? RESP_SLVERR : RESP_OKAY;
      end
      if (bvalid_o && bready_i) begin
        bvalid_o  <= 1'b0;
        awready_o <= 1'b1;
        wready_o  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ir_en_reg     <= 1'b0;
      host_pend_reg <= 1'b0;
      ir_pend_reg   <= 1'b0;
      host_byte_reg <= 8'h00;
      ir_byte_reg   <= 8'h00;
    end else begin
      if (wr_fire && !wr_err && wbyte_reg) begin
        if (waddr_reg == REG_CTRL) begin
          ir_en_reg <= wdata_reg[CTRL_IR_EN];
        end else if (waddr_reg == REG_IR_TX) begin
          ir_byte_reg <= wdata_reg[7:0];
          ir_pend_reg <= 1'b1;
        end else if (waddr_reg == REG_HOST_TX) begin
          host_byte_reg <= wdata_reg[7:0];
          host_pend_reg <= 1'b1;
        end
      end
      if (!run || (host_tx.valid && host_tx.ready)) begin
        host_pend_reg <= 1'b0;
      end
      if (!run || (ir_tx.valid && ir_tx.ready)) begin
        ir_pend_reg <= 1'b0;
      end
    end
  end

  // register read channel; reading the receive data pops one byte
  logic [31:0] status_word;
  logic        ar_take;

  assign ar_take = arvalid_i && arready_o;
  assign rx_pop  = ar_take && araddr_i == REG_HOST_RX && level_reg != '0;

  always_comb begin
    status_word                   = 32'h0000_0000;
    status_word[ST_RUN_BIT]       = run;
    status_word[ST_CARRIER]       = !carrier_n; // [R3]
    status_word[ST_HOST_READY]    = !rts_n; // [R2]
    status_word[ST_CTS_HELD]      = clear_to_send_n_o;
    status_word[ST_IR_PEND]       = ir_pend_reg;
    status_word[ST_HOST_PEND]     = host_pend_reg;
    status_word[ST_OVERFLOW]      = overflow_reg;
    status_word[ST_LEVEL_LSB +: LVL_W] = level_reg;
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      arready_o <= 1'b1;
      rvalid_o  <= 1'b0;
      rdata_o   <= 32'h0000_0000;
      rresp_o   <= RESP_OKAY;
    end else if (ar_take) begin
      arready_o <= 1'b0;
      rvalid_o  <= 1'b1;
      rresp_o   <= RESP_OKAY;
      rdata_o   <= 32'h0000_0000;
      if (araddr_i == REG_CTRL) begin
        rdata_o[CTRL_IR_EN] <= ir_en_reg;
      end else if (araddr_i == REG_STATUS) begin
        rdata_o <= status_word;
      end else if (araddr_i == REG_HOST_RX) begin
        rdata_o[RX_VALID_BIT] <= rx_pop;
        rdata_o[7:0] <= rx_pop ? rx_mem[rd_ptr_reg] : 8'h00;
      end else if (araddr_i == REG_IR_TX || araddr_i == REG_HOST_TX) begin
        rresp_o <= RESP_OKAY;
      end else begin
        rresp_o <= RESP_SLVERR;
      end
    end else if (rvalid_o && rready_i) begin
      rvalid_o  <= 1'b0;
      arready_o <= 1'b1;
    end
  end
endmodule : ir_bridge_host_lines_startup
`default_nettype wire

// >>> verilog/ir_bridge_pkg.sv
// constants for the infrared bridge host-line and start-up core
// Contract
// R1: host drives request-to-send low when ready to take data, high when not.
// R2: request-to-send is local flow control only, never tied to remote bits.
// R3: sample carrier-detect and report it; low is carrier, high is none.
// R4: host serial and infrared ports run fixed 9600 baud from device clock.
// R5: after power-up run power-up delay, then oscillator start-up delay.
// R6: no traffic on either side until both start-up delays have finished.
// R7: device stays in reset while the reset input is low.
// R8: after reset goes high, finish the reset sequence, then operate.
// R9: all timing, bit clock included, comes from the single device clock.
// R10: sixteen bit-clock ticks make one serial bit time.
// R11: zero bit is low 7, high 3, low 6 ticks; one bit stays low.
// R12: clear-to-send low lets host send, high stops it, by buffer room.
// R13: after clear-to-send goes high still accept six more host bytes.
// R14: reset, request-to-send and carrier-detect are synchronised first.
package ir_bridge_pkg;
  localparam int unsigned CLK_HZ        = 250_000_000;
  localparam int unsigned CLK_MHZ       = CLK_HZ / 1_000_000;
  localparam int unsigned BAUD_RATE     = 9600;
  localparam int unsigned TICKS_PER_BIT = 16;
  localparam int unsigned TICK_DIV      =
    (CLK_HZ + BAUD_RATE * TICKS_PER_BIT / 2) / (BAUD_RATE * TICKS_PER_BIT);
  localparam int unsigned POWER_UP_DELAY_US = 1000;
  localparam int unsigned POWER_UP_CYCLES   = POWER_UP_DELAY_US * CLK_MHZ;
  localparam int unsigned OSC_START_DELAY_US = 200;
  localparam int unsigned OSC_START_CYCLES   = OSC_START_DELAY_US * CLK_MHZ;
  localparam logic [3:0] IR_PULSE_FIRST = 4'h7;
  localparam logic [3:0] IR_PULSE_LAST  = 4'h9;
  localparam logic [3:0] TICK_LAST      = 4'hF;
  localparam logic [3:0] RX_MID_TICK    = 4'h7;
  localparam logic [3:0] STOP_BIT_IDX   = 4'h9;
  localparam int unsigned HOST_RX_DEPTH = 29;
  localparam int unsigned CTS_SLACK     = 6;
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_STATUS  = 8'h04;
  localparam logic [7:0] REG_IR_TX   = 8'h08;
  localparam logic [7:0] REG_HOST_TX = 8'h0C;
  localparam logic [7:0] REG_HOST_RX = 8'h10;
  localparam int unsigned CTRL_IR_EN     = 0;
  localparam int unsigned CTRL_OVF_CLR   = 1;
  localparam int unsigned ST_RUN_BIT     = 0;
  localparam int unsigned ST_CARRIER     = 1;
  localparam int unsigned ST_HOST_READY  = 2;
  localparam int unsigned ST_CTS_HELD    = 3;
  localparam int unsigned ST_IR_PEND     = 4;
  localparam int unsigned ST_HOST_PEND   = 5;
  localparam int unsigned ST_OVERFLOW    = 6;
  localparam int unsigned ST_LEVEL_LSB   = 8;
  localparam int unsigned RX_VALID_BIT   = 8;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    ST_POWER_UP  = 3'h1,
    ST_OSC_START = 3'h2,
    ST_RUN       = 3'h4
  } startup_state_t;
endpackage : ir_bridge_pkg

// >>> verilog/serial_shifter.sv
// ten-bit frame shifter, plain serial or pulse-coded infrared line
`timescale 1ns/100ps
`default_nettype none
module serial_shifter
  import ir_bridge_pkg::*;
#(
  parameter bit INFRARED = 1'b0
) (
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        run_i,
  input  wire logic        tick_i,
  byte_stream_if.snk       feed,
  output var  logic        line_o
);
  localparam logic IDLE_LEVEL = !INFRARED;

  logic [9:0] frame_reg;
  logic [3:0] tick_reg;
  logic [3:0] bit_reg;
  logic       active_reg;

  assign feed.ready = run_i && !active_reg;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      frame_reg  <= 10'h3FF;
      tick_reg   <= 4'h0;
      bit_reg    <= 4'h0;
      active_reg <= 1'b0;
    end else if (!run_i) begin // [R6]
      active_reg <= 1'b0;
    end else if (!active_reg) begin
      if (feed.valid) begin
        frame_reg  <= {1'b1, feed.data, 1'b0};
        tick_reg   <= 4'h0;
        bit_reg    <= 4'h0;
        active_reg <= 1'b1;
      end
    end else if (tick_i) begin
      tick_reg <= tick_reg + 4'h1; // [R10]
      if (tick_reg == TICK_LAST) begin
        frame_reg <= {1'b1, frame_reg[9:1]};
        bit_reg   <= bit_reg + 4'h1;
        if (bit_reg == STOP_BIT_IDX) begin
          active_reg <= 1'b0;
        end
      end
    end
  end

  // infrared: zero bits carry a three-tick pulse, ones leave the line low; plain serial follows the frame bit
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      line_o <= IDLE_LEVEL;
    end else if (!active_reg) begin
      line_o <= IDLE_LEVEL;
    end else if (INFRARED) begin
      line_o <= !frame_reg[0] && tick_reg >= IR_PULSE_FIRST
                && tick_reg <= IR_PULSE_LAST; // [R11]
    end else begin
      line_o <= frame_reg[0];
    end
  end
endmodule : serial_shifter
`default_nettype wire
